// >>> inc/hvm_params.svh
`ifndef HVM_PARAMS_SVH
`define HVM_PARAMS_SVH
// register offsets (4-bit word index on the plain port)
`define HVM_OFF_MEAS_CTRL 4'h0
`define HVM_OFF_PIN_CFG 4'h1
`define HVM_OFF_WAKE_CTRL 4'h2
`define HVM_OFF_PULL_CFG 4'h3
`define HVM_OFF_WAKE_STAT0 4'h4
`define HVM_OFF_WAKE_STAT1 4'h5
`define HVM_OFF_LVL_STAT 4'h6
`define HVM_OFF_MODE 4'h7
`define HVM_OFF_IRQ_STAT 4'h8
`define HVM_OFF_IRQ_MASK 4'h9
`define HVM_OFF_ROUTE_STAT 4'ha
// field positions
`define HVM_BIT_MEAS_EN 0
`define HVM_BIT_SENSE_WK 0
`define HVM_BIT_PIN_WK 1
`define HVM_BIT_FO_TEST 2
`define HVM_BIT_PULL_SENSE_UP 0
`define HVM_BIT_PULL_SENSE_DN 1
`define HVM_BIT_PULL_PIN_UP 2
`define HVM_BIT_PULL_PIN_DN 3
`define HVM_BIT_CMD_ERR 0
`define HVM_BIT_SW_CLOSED 1
`define HVM_BIT_SENSE_EDGE 2
`define HVM_BIT_PIN_EDGE 3
// reset values
`define HVM_RST_BYTE 8'h00
`define HVM_RST_PIN_CFG 3'h0
`define HVM_RST_MODE 3'h0
`endif

// >>> inc/hvm_pkg.sv
package hvm_pkg;
    typedef enum logic [2:0] {
        HVM_MODE_INIT = 3'b000,
        HVM_MODE_NORMAL = 3'b001,
        HVM_MODE_STOP = 3'b010,
        HVM_MODE_SLEEP = 3'b011,
        HVM_MODE_RESTART = 3'b100,
        HVM_MODE_FAILSAFE = 3'b101
    } hvm_mode_t;
    typedef enum logic [2:0] {
        HVM_PIN_OFF = 3'b000,
        HVM_PIN_FAIL_OUT = 3'b001,
        HVM_PIN_WAKE_IN = 3'b010,
        HVM_PIN_LOW_SIDE = 3'b011,
        HVM_PIN_HIGH_SIDE = 3'b100
    } hvm_pin_cfg_t;
endpackage

// >>> inc/hvm_pin_if.sv
`timescale 1ns/100ps
interface hvm_pin_if;
    logic gate;
    logic raw_in;
    logic pull_up_cfg;
    logic pull_dn_cfg;
    logic level;
    logic edge_seen;
    logic pull_up;
    logic pull_dn;
    modport ctrl (output gate, raw_in, pull_up_cfg, pull_dn_cfg, input level, edge_seen,
        pull_up, pull_dn);
    modport cond (input gate, raw_in, pull_up_cfg, pull_dn_cfg, output level, edge_seen,
        pull_up, pull_dn);
endinterface

// >>> design/hvm_pin_cond.sv
`timescale 1ns/100ps
`include "hvm_params.svh"
module hvm_pin_cond (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // pin side
    hvm_pin_if.cond pin
);
    logic prev_q;
    logic prev_d;
    logic level_q;
    logic level_d;
    logic edge_q;
    logic edge_d;
    logic pu_q;
    logic pu_d;
    logic pd_q;
    logic pd_d;

    always_comb begin
        prev_d = pin.raw_in; // tracked while gated too, so ungating shows no false edge
        level_d = pin.gate ? 1'b0 : pin.raw_in;
        edge_d = !pin.gate && (pin.raw_in != prev_q);
        pu_d = pin.pull_up_cfg && !pin.gate;
        pd_d = pin.pull_dn_cfg && !pin.gate;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev_q <= 1'b0;
            level_q <= 1'b0;
            edge_q <= 1'b0;
            pu_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            level_q <= level_d;
            edge_q <= edge_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
        end
    end

    assign pin.level = level_q;
    assign pin.edge_seen = edge_q;
    assign pin.pull_up = pu_q;
    assign pin.pull_dn = pd_q;
endmodule // hvm_pin_cond

// >>> design/hvm_route_ctrl.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "hvm_params.svh"
module hvm_route_ctrl (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // mode machine
    input wire logic sleep_cmd_in,
    input wire logic timer_wake_en_in,
    input wire logic mode_req_in,
    input wire logic [2:0] mode_req_val_in,
    input wire logic fail_safe_in,
    output logic restart_req_out,
    // pins
    input wire logic sense_raw_in,
    input wire logic pin_raw_in,
    output logic switch_close_out,
    output logic pin_out_out,
    output logic pin_oe_out,
    output logic sense_pull_up_out,
    output logic sense_pull_dn_out,
    output logic pin_pull_up_out,
    output logic pin_pull_dn_out,
    output logic sense_wake_out,
    output logic irq_out
);
    hvm_pin_if sense_if ();
    hvm_pin_if pin_if ();

    hvm_pin_cond u_sense (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .pin(sense_if.cond)
    );
    hvm_pin_cond u_pin (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .pin(pin_if.cond)
    );

    hvm_pkg::hvm_mode_t mode_q, mode_d;
    logic meas_en_q, meas_en_d;
    logic [2:0] pin_cfg_q, pin_cfg_d;
    logic [7:0] wake_ctrl_q, wake_ctrl_d;
    logic [7:0] pull_cfg_q, pull_cfg_d;
    logic [7:0] wstat0_q, wstat0_d;
    logic [7:0] wstat1_q, wstat1_d;
    logic [7:0] lvl_q, lvl_d;
    logic [7:0] irq_stat_q, irq_stat_d;
    logic [7:0] irq_mask_q, irq_mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic sw_q, sw_d;
    logic pin_out_q, pin_out_d;
    logic pin_oe_q, pin_oe_d;
    logic restart_q, restart_d;
    logic sense_wake_q, sense_wake_d;
    logic irq_q, irq_d;
    logic cmd_err;
    logic pin_wake_en;
    logic wr_meas, wr_pin, wr_wake, wr_pull, wr_mode;
    logic [7:0] set_ev;

    assign wr_meas = reg_wr_in && reg_addr_in == `HVM_OFF_MEAS_CTRL;
    assign wr_pin = reg_wr_in && reg_addr_in == `HVM_OFF_PIN_CFG;
    assign wr_wake = reg_wr_in && reg_addr_in == `HVM_OFF_WAKE_CTRL;
    assign wr_pull = reg_wr_in && reg_addr_in == `HVM_OFF_PULL_CFG;
    assign wr_mode = reg_wr_in && reg_addr_in == `HVM_OFF_MODE;
    assign pin_wake_en = pin_cfg_q == hvm_pkg::HVM_PIN_WAKE_IN;

    // pins see the gate and, only while not measuring, their own pull settings;
    // the gate follows the next enable so pulls drop on the edge the switch closes
    assign sense_if.gate = meas_en_d;
    assign sense_if.raw_in = sense_raw_in;
    assign sense_if.pull_up_cfg = pull_cfg_q[`HVM_BIT_PULL_SENSE_UP];
    assign sense_if.pull_dn_cfg = pull_cfg_q[`HVM_BIT_PULL_SENSE_DN];
    assign pin_if.gate = meas_en_d;
    assign pin_if.raw_in = pin_raw_in;
    assign pin_if.pull_up_cfg = pull_cfg_q[`HVM_BIT_PULL_PIN_UP];
    assign pin_if.pull_dn_cfg = pull_cfg_q[`HVM_BIT_PULL_PIN_DN];

    always_comb begin
        meas_en_d = meas_en_q;
        pin_cfg_d = pin_cfg_q;
        wake_ctrl_d = wake_ctrl_q;
        pull_cfg_d = pull_cfg_q;
        mode_d = mode_q;
        restart_d = 1'b0;
        cmd_err = 1'b0;
        // writing 0 is always taken; 1 only from a pin that is Off
        if (wr_meas) begin
            if (reg_wdata_in[`HVM_BIT_MEAS_EN] && !meas_en_q
                    && pin_cfg_q != hvm_pkg::HVM_PIN_OFF) begin
                cmd_err = 1'b1;
            end else begin
                meas_en_d = reg_wdata_in[`HVM_BIT_MEAS_EN];
            end
        end
        if (wr_pin) begin
            pin_cfg_d = reg_wdata_in[2:0];
            // stored anyway, but a changed value is flagged while measuring
            if (meas_en_q && reg_wdata_in[2:0] != pin_cfg_q) begin
                cmd_err = 1'b1;
            end
        end
        if (wr_wake) begin
            wake_ctrl_d = reg_wdata_in;
        end
        if (wr_pull) begin
            pull_cfg_d = reg_wdata_in;
        end
        if (wr_mode) begin
            mode_d = hvm_pkg::hvm_mode_t'(reg_wdata_in[2:0]);
        end else if (mode_req_in) begin
            mode_d = hvm_pkg::hvm_mode_t'(mode_req_val_in);
        end
        if (sleep_cmd_in) begin
            // pin-based wakes are dead while measuring; sleep would never wake
            if (meas_en_q && !timer_wake_en_in
                    && (wake_ctrl_q[`HVM_BIT_SENSE_WK] || pin_wake_en)) begin
                cmd_err = 1'b1;
                mode_d = hvm_pkg::HVM_MODE_RESTART;
                restart_d = 1'b1;
            end else begin
                mode_d = hvm_pkg::HVM_MODE_SLEEP;
            end
        end
        if (fail_safe_in) begin
            mode_d = hvm_pkg::HVM_MODE_FAILSAFE;
        end
    end

    always_comb begin
        wstat0_d = wstat0_q;
        wstat1_d = wstat1_q;
        lvl_d = lvl_q;
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (reg_wr_in && reg_addr_in == `HVM_OFF_WAKE_STAT0) begin
            wstat0_d = wstat0_q & ~reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `HVM_OFF_WAKE_STAT1) begin
            wstat1_d = wstat1_q & ~reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `HVM_OFF_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `HVM_OFF_IRQ_MASK) begin
            irq_mask_d = reg_wdata_in;
        end
        // edges feed status only when not measuring; set wins over clear
        if (!meas_en_q) begin
            if (sense_if.edge_seen && wake_ctrl_q[`HVM_BIT_SENSE_WK]) begin
                wstat0_d[0] = 1'b1;
            end
            if (pin_if.edge_seen && pin_wake_en) begin
                wstat1_d[0] = 1'b1;
            end
            lvl_d = {6'h00, pin_if.level, sense_if.level};
        end
        // edge bits need no test of the enable: the conditioners gate them
        set_ev = 8'h00;
        set_ev[`HVM_BIT_CMD_ERR] = cmd_err;
        set_ev[`HVM_BIT_SENSE_EDGE] = sense_if.edge_seen;
        set_ev[`HVM_BIT_PIN_EDGE] = pin_if.edge_seen;
        irq_stat_d = irq_stat_d | set_ev;
        // level taken from the next status so it rises with the flag itself
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    always_comb begin
        // closed only in Normal Mode with the enable stored; every other mode keeps
        // the stored bit but opens the switch, so no divider current in low power
        sw_d = 1'b0;
        if (meas_en_d && mode_d == hvm_pkg::HVM_MODE_NORMAL) begin
            sw_d = 1'b1;
        end
        if (mode_d != hvm_pkg::HVM_MODE_NORMAL) begin
            sw_d = 1'b0;
        end
        if (mode_d == hvm_pkg::HVM_MODE_FAILSAFE) begin
            sw_d = 1'b0;
        end
        // pin driver off while measuring and while the switch routes
        pin_oe_d = 1'b0;
        pin_out_d = 1'b0;
        if (!meas_en_d) begin
            case (pin_cfg_d)
                hvm_pkg::HVM_PIN_FAIL_OUT: begin
                    pin_oe_d = mode_d == hvm_pkg::HVM_MODE_FAILSAFE
                        || wake_ctrl_d[`HVM_BIT_FO_TEST];
                    pin_out_d = 1'b0;
                end
                hvm_pkg::HVM_PIN_LOW_SIDE: begin
                    pin_oe_d = 1'b1;
                    pin_out_d = 1'b0;
                end
                hvm_pkg::HVM_PIN_HIGH_SIDE: begin
                    pin_oe_d = 1'b1;
                    pin_out_d = 1'b1;
                end
                default: begin
                    pin_oe_d = 1'b0;
                    pin_out_d = 1'b0;
                end
            endcase
        end
        // enable never sets unless pin is Off, so fail-output role excludes routing
        if (pin_cfg_d == hvm_pkg::HVM_PIN_FAIL_OUT) sw_d = 1'b0;
        sense_wake_d = !meas_en_d && wake_ctrl_d[`HVM_BIT_SENSE_WK];
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `HVM_OFF_MEAS_CTRL: rdata_d = {7'h00, meas_en_q};
                `HVM_OFF_PIN_CFG: rdata_d = {5'h00, pin_cfg_q};
                `HVM_OFF_WAKE_CTRL: rdata_d = wake_ctrl_q;
                `HVM_OFF_PULL_CFG: rdata_d = pull_cfg_q;
                `HVM_OFF_WAKE_STAT0: rdata_d = wstat0_q;
                `HVM_OFF_WAKE_STAT1: rdata_d = wstat1_q;
                `HVM_OFF_LVL_STAT: rdata_d = lvl_q;
                `HVM_OFF_MODE: rdata_d = {5'h00, mode_q};
                `HVM_OFF_IRQ_STAT: rdata_d = irq_stat_q;
                `HVM_OFF_IRQ_MASK: rdata_d = irq_mask_q;
                `HVM_OFF_ROUTE_STAT: rdata_d = {6'h00, sw_q, meas_en_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_q <= hvm_pkg::hvm_mode_t'(`HVM_RST_MODE);
            meas_en_q <= 1'b0;
            pin_cfg_q <= `HVM_RST_PIN_CFG;
            wake_ctrl_q <= `HVM_RST_BYTE;
            pull_cfg_q <= `HVM_RST_BYTE;
            wstat0_q <= `HVM_RST_BYTE;
            wstat1_q <= `HVM_RST_BYTE;
            lvl_q <= `HVM_RST_BYTE;
            irq_stat_q <= `HVM_RST_BYTE;
            irq_mask_q <= `HVM_RST_BYTE;
            rdata_q <= `HVM_RST_BYTE;
            sw_q <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
            restart_q <= 1'b0;
            sense_wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            meas_en_q <= meas_en_d;
            pin_cfg_q <= pin_cfg_d;
            wake_ctrl_q <= wake_ctrl_d;
            pull_cfg_q <= pull_cfg_d;
            wstat0_q <= wstat0_d;
            wstat1_q <= wstat1_d;
            lvl_q <= lvl_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            rdata_q <= rdata_d;
            sw_q <= sw_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            restart_q <= restart_d;
            sense_wake_q <= sense_wake_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign restart_req_out = restart_q;
    assign switch_close_out = sw_q;
    assign pin_out_out = pin_out_q;
    assign pin_oe_out = pin_oe_q;
    assign sense_pull_up_out = sense_if.pull_up;
    assign sense_pull_dn_out = sense_if.pull_dn;
    assign pin_pull_up_out = pin_if.pull_up;
    assign pin_pull_dn_out = pin_if.pull_dn;
    assign sense_wake_out = sense_wake_q;
    assign irq_out = irq_q;
endmodule // hvm_route_ctrl

// >>> tb/hvm_adc_model.sv
`timescale 1ns/100ps
module hvm_adc_model (
    // clock
    input wire logic mclk_in,
    // divider node as seen by the converter
    input wire logic switch_close_in,
    input wire logic pin_oe_in,
    input wire logic sense_level_in,
    // converted level
    output logic sample_out
);
    initial sample_out = 1'b0;
    // an open switch or a driven pin gives no valid node, so show the inverse of the last sample
    always @(posedge mclk_in) begin
        if (switch_close_in && !pin_oe_in) begin
            sample_out <= sense_level_in;
        end else begin
            sample_out <= ~sample_out;
        end
    end
endmodule // hvm_adc_model

// >>> tb/hvm_route_ctrl_sva.sv
`timescale 1ns/100ps
`include "hvm_params.svh"
module hvm_route_ctrl_sva (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // register port and mode machine
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic sleep_cmd_in,
    input wire logic mode_req_in,
    input wire logic [2:0] mode_req_val_in,
    input wire logic fail_safe_in,
    input wire logic restart_req_out,
    // pins
    input wire logic switch_close_out,
    input wire logic pin_oe_out,
    input wire logic sense_pull_up_out,
    input wire logic sense_pull_dn_out,
    input wire logic pin_pull_up_out,
    input wire logic pin_pull_dn_out,
    input wire logic sense_wake_out,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_leave_normal;
        mode_req_in && mode_req_val_in != 3'h1
            && !(reg_wr_in && reg_addr_in == `HVM_OFF_MODE);
    endsequence
    sequence s_pulls_off;
        !(sense_pull_up_out || sense_pull_dn_out || pin_pull_up_out || pin_pull_dn_out);
    endsequence
    a_reset_switch_open: assert property ($rose(reset_n_in) |-> !switch_close_out)
        else $error("switch closed right after reset");
    a_closed_pulls_off: assert property (switch_close_out |-> s_pulls_off)
        else $error("pull source on while routing");
    a_closed_no_drive: assert property (switch_close_out |-> !pin_oe_out)
        else $error("pin driven while routing");
    a_closed_no_wake: assert property (switch_close_out |-> !sense_wake_out)
        else $error("sense wake active while routing");
    a_leave_normal_open: assert property (s_leave_normal |=> !switch_close_out)
        else $error("switch closed outside normal mode");
    a_fail_safe_open: assert property (fail_safe_in |=> !switch_close_out)
        else $error("switch closed in fail-safe");
    a_close_has_cause: assert property
        ($rose(switch_close_out) |-> $past(reg_wr_in) || $past(mode_req_in))
        else $error("switch closed without a request");
    a_restart_from_sleep: assert property
        (restart_req_out |-> $past(sleep_cmd_in) || $past(sleep_cmd_in, 2))
        else $error("restart without a sleep command");
    a_restart_is_pulse: assert property (restart_req_out |=> !restart_req_out)
        else $error("restart request longer than one cycle");
    a_error_sticky: assert property (irq_out && !reg_wr_in |=> irq_out)
        else $error("interrupt dropped without a write");
endmodule // hvm_route_ctrl_sva
bind hvm_route_ctrl hvm_route_ctrl_sva hvm_route_ctrl_sva_i (.mclk_in, .reset_n_in,
    .reg_addr_in, .reg_wr_in, .sleep_cmd_in, .mode_req_in, .mode_req_val_in, .fail_safe_in,
    .restart_req_out, .switch_close_out, .pin_oe_out, .sense_pull_up_out, .sense_pull_dn_out,
    .pin_pull_up_out, .pin_pull_dn_out, .sense_wake_out, .irq_out);

// >>> tb/hvm_route_ctrl_test.sv
`timescale 1ns/100ps
`include "hvm_params.svh"
module hvm_route_ctrl_test;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic sleep_cmd_in = 1'b0;
    logic timer_wake_en_in = 1'b0;
    logic mode_req_in = 1'b0;
    logic [2:0] mode_req_val_in = 3'h0;
    logic fail_safe_in = 1'b0;
    logic sense_raw_in = 1'b0;
    logic pin_raw_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic restart_req_out, switch_close_out, pin_out_out, pin_oe_out, irq_out;
    logic sense_pull_up_out, sense_pull_dn_out, pin_pull_up_out, pin_pull_dn_out;
    logic sense_wake_out, adc_sample;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 mclk_in = ~mclk_in;
    hvm_route_ctrl hvm_route_ctrl_i (.mclk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sleep_cmd_in, .timer_wake_en_in, .mode_req_in,
        .mode_req_val_in, .fail_safe_in, .restart_req_out, .sense_raw_in, .pin_raw_in,
        .switch_close_out, .pin_out_out, .pin_oe_out, .sense_pull_up_out, .sense_pull_dn_out,
        .pin_pull_up_out, .pin_pull_dn_out, .sense_wake_out, .irq_out);
    hvm_adc_model hvm_adc_model_i (.mclk_in, .switch_close_in(switch_close_out),
        .pin_oe_in(pin_oe_out), .sense_level_in(sense_raw_in), .sample_out(adc_sample));
    wire logic [7:0] pulls = {4'h0, sense_pull_up_out, sense_pull_dn_out, pin_pull_up_out,
        pin_pull_dn_out};
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input string n, input logic [7:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(n, reg_rdata_out, exp);
    endtask
    task automatic pause;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic go_mode(input logic [2:0] m);
        @(posedge mclk_in);
        mode_req_in <= 1'b1;
        mode_req_val_in <= m;
        @(posedge mclk_in);
        mode_req_in <= 1'b0;
        pause();
    endtask
    task automatic t_reset;
        chk("switch", 8'(switch_close_out), 8'h00);
        chk("pulls", pulls, 8'h00);
        rd(`HVM_OFF_ROUTE_STAT, "route", 8'h00);
        rd(`HVM_OFF_PIN_CFG, "pin_cfg", 8'h00);
    endtask
    task automatic t_enable;
        go_mode(3'h1);
        wr(`HVM_OFF_PULL_CFG, 8'h05);
        wr(`HVM_OFF_WAKE_CTRL, 8'h01);
        wr(`HVM_OFF_IRQ_MASK, 8'h0d);
        pause();
        chk("pulls_before", pulls, 8'h0a);
        chk("wake_before", 8'(sense_wake_out), 8'h01);
        wr(`HVM_OFF_MEAS_CTRL, 8'h01);
        pause();
        chk("switch", 8'(switch_close_out), 8'h01);
        chk("pulls", pulls, 8'h00);
        chk("wake", 8'(sense_wake_out), 8'h00);
        chk("pin_oe", 8'(pin_oe_out), 8'h00);
        rd(`HVM_OFF_ROUTE_STAT, "route", 8'h03);
        wr(`HVM_OFF_PULL_CFG, 8'h0a);
        rd(`HVM_OFF_PULL_CFG, "pull_cfg", 8'h0a);
        chk("pulls_ignored", pulls, 8'h00);
        @(posedge mclk_in);
        sense_raw_in <= 1'b1;
        pin_raw_in <= 1'b1;
        repeat (4) pause();
        chk("adc", 8'(adc_sample), 8'h01);
        rd(`HVM_OFF_WAKE_STAT0, "stat0", 8'h00);
        rd(`HVM_OFF_WAKE_STAT1, "stat1", 8'h00);
        rd(`HVM_OFF_LVL_STAT, "level", 8'h00);
        rd(`HVM_OFF_IRQ_STAT, "edges", 8'h00);
    endtask
    task automatic t_modes;
        logic [2:0] ms[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
        foreach (ms[i]) begin
            go_mode(ms[i]);
            chk("switch_off", 8'(switch_close_out), 8'h00);
            go_mode(3'h1);
            chk("switch_on", 8'(switch_close_out), 8'h01);
        end
        @(posedge mclk_in);
        fail_safe_in <= 1'b1;
        @(posedge mclk_in);
        fail_safe_in <= 1'b0;
        pause();
        chk("fail_safe", 8'(switch_close_out), 8'h00);
        rd(`HVM_OFF_MEAS_CTRL, "kept", 8'h01);
        go_mode(3'h1);
    endtask
    task automatic t_sleep;
        logic got;
        got = 1'b0;
        // another wake source present: sleep is taken, no error
        @(posedge mclk_in);
        timer_wake_en_in <= 1'b1;
        sleep_cmd_in <= 1'b1;
        @(posedge mclk_in);
        sleep_cmd_in <= 1'b0;
        timer_wake_en_in <= 1'b0;
        #1;
        chk("no_restart", 8'(restart_req_out), 8'h00);
        rd(`HVM_OFF_MODE, "slept", 8'h03);
        rd(`HVM_OFF_IRQ_STAT, "no_err", 8'h00);
        go_mode(3'h1);
        @(posedge mclk_in);
        sleep_cmd_in <= 1'b1;
        @(posedge mclk_in);
        sleep_cmd_in <= 1'b0;
        repeat (3) begin
            #1;
            got = got | restart_req_out;
            @(posedge mclk_in);
        end
        chk("restart", 8'(got), 8'h01);
        rd(`HVM_OFF_MODE, "mode", 8'h04);
        rd(`HVM_OFF_IRQ_STAT, "err", 8'h01);
        wr(`HVM_OFF_IRQ_STAT, 8'h01);
        go_mode(3'h1);
    endtask
    task automatic t_pin_cfg;
        wr(`HVM_OFF_PIN_CFG, 8'h02);
        pause();
        chk("irq", 8'(irq_out), 8'h01);
        repeat (3) pause();
        chk("sticky", 8'(irq_out), 8'h01);
        rd(`HVM_OFF_IRQ_STAT, "err", 8'h01);
        wr(`HVM_OFF_IRQ_STAT, 8'h01);
        pause();
        chk("cleared", 8'(irq_out), 8'h00);
        wr(`HVM_OFF_MEAS_CTRL, 8'h00);
        rd(`HVM_OFF_LVL_STAT, "level_back", 8'h03);
        for (int v = 1; v <= 4; v++) begin
            wr(`HVM_OFF_PIN_CFG, 8'(v));
            wr(`HVM_OFF_MEAS_CTRL, 8'h01);
            rd(`HVM_OFF_ROUTE_STAT, "refused", 8'h00);
            chk("pin_oe_kept", 8'(pin_oe_out), (v >= 3) ? 8'h01 : 8'h00);
            chk("pin_out_kept", 8'(pin_out_out), (v == 4) ? 8'h01 : 8'h00);
            rd(`HVM_OFF_IRQ_STAT, "err", 8'h01);
            wr(`HVM_OFF_IRQ_STAT, 8'h01);
        end
    endtask
    task automatic t_rerun;
        wr(`HVM_OFF_PIN_CFG, 8'h00);
        wr(`HVM_OFF_MEAS_CTRL, 8'h01);
        pause();
        chk("switch_again", 8'(switch_close_out), 8'h01);
        @(posedge mclk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        pause();
        chk("switch_rst", 8'(switch_close_out), 8'h00);
        chk("pulls_rst", pulls, 8'h00);
        rd(`HVM_OFF_ROUTE_STAT, "route_rst", 8'h00);
        rd(`HVM_OFF_MODE, "mode_rst", 8'h00);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // a hang is cut well past the fewer than 200 cycles the scenarios need
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        pause();
        t_reset();
        t_enable();
        t_modes();
        t_sleep();
        t_pin_cfg();
        t_rerun();
        give_verdict();
    end
endmodule // hvm_route_ctrl_test
